// ---- hw/camera_feature_inquiry_regs.sv ----
// capability inquiry register bank of the camera, reached over wishbone
//
// Operation
// - each presence bit reads 1 when its feature or function is available and 0 when not.
// - availability follows the variant strap and the mono bit of the video selection at every read; format and mode have no effect.
// - high presence bits 0..7 are brightness, auto exposure, sharpness, white balance, hue, saturation, gamma, shutter.
// - high presence bits 8..15 are gain, iris, focus, temperature, trigger, trigger delay, white shading, frame-rate priority; 16..31 reserved.
// - brightness, shutter, gain and trigger are present on both variants, white balance only on the colour one, the rest absent.
// - low presence maps zoom, pan, tilt, optical filter to 0..3 and capture size and quality to 16, 17, all reading 0.
// - optional function bits are parallel io at 1, serial io at 2, strobe at 3, reading 1, 0, 1.
// - a pointer word gives the quadlet offset of the vendor feature block, present on every variant.
// - a pointer word gives the quadlet offset of the parallel io block, present on every variant.
// - a pointer word gives the quadlet offset of the strobe output block, present on every variant.
// - the basic function word reports the optional function space at bit 3 as 1.
`timescale 1ns/1ps
`default_nettype none

module camera_feature_inquiry_regs
   import feature_inquiry_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic colour_variant_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [DATA_W-1:0] dat_i,
   output logic [DATA_W-1:0] dat_o,
   output logic ack_o,
   output logic [2:0] video_format_o,
   output logic [2:0] video_mode_o
);

   // ****************************************************************
   // bus handshake
   // ****************************************************************
   logic load;
   logic write;

   wb_word_slave u_slave (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .ack_o(ack_o),
      .load_o(load),
      .write_o(write)
   );

   logic [ADDR_W-1:0] word_addr;
   assign word_addr = {adr_i[ADDR_W-1:2], 2'b00};

   // ****************************************************************
   // variant strap
   // ****************************************************************
   // the strap is caught while reset is held, so it settles before use
   logic colour_variant;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         colour_variant <= colour_variant_i;
      end
   end

   // ****************************************************************
   // video selection (writable)
   // ****************************************************************
   logic [2:0] video_format;
   logic [2:0] video_mode;
   logic video_mono;
   logic select_write;

   assign select_write = write && (word_addr == OFS_VIDEO_SELECT);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         video_format <= VIDEO_FORMAT_RESET;
         video_mode <= VIDEO_MODE_RESET;
         video_mono <= VIDEO_MONO_RESET;
      end else if (ce_i && select_write) begin
         if (sel_i[0]) begin
            video_format <= dat_i[SEL_FORMAT_LSB +: 3];
            video_mode <= dat_i[SEL_MODE_LSB +: 3];
         end
         if (sel_i[1]) begin
            video_mono <= dat_i[SEL_MONO_BIT];
         end
      end
   end

   assign video_format_o = video_format;
   assign video_mode_o = video_mode;

   // ****************************************************************
   // presence fields, indexed with bit 0 as msb
   // ****************************************************************
   logic [31:0] basic_field;
   logic [31:0] high_field;
   logic [31:0] low_field;
   logic [31:0] optional_field;
   logic colour_active;

   // a monochrome output mode hides colour controls even on colour parts
   assign colour_active = colour_variant && !video_mono;

   always_comb begin
      basic_field = '0;
      basic_field[POS_VENDOR_FEATURE] = 1'b1;
      basic_field[POS_VMODE_ERROR] = 1'b1;
      basic_field[POS_FEATURE_ERROR] = 1'b1;
      basic_field[POS_OPTIONAL_CSR] = 1'b1;
      basic_field[POS_MODE_1394B] = 1'b0;
      basic_field[POS_POWER_CTRL] = 1'b0;
      basic_field[POS_ONE_SHOT] = 1'b1;
      basic_field[POS_MULTI_SHOT] = 1'b0;
      for (int i = 0; i < MEM_CHANNEL_W; i++) begin
         // field msb sits at the lowest position number
         basic_field[POS_MEM_CHANNEL_MSB + i] = MEM_CHANNEL_COUNT[MEM_CHANNEL_W - 1 - i];
      end
   end

   always_comb begin
      high_field = '0;
      high_field[POS_BRIGHTNESS] = 1'b1;
      high_field[POS_AUTO_EXPOSURE] = 1'b0;
      high_field[POS_SHARPNESS] = 1'b0;
      high_field[POS_WHITE_BALANCE] = colour_active;
      high_field[POS_HUE] = 1'b0;
      high_field[POS_SATURATION] = 1'b0;
      high_field[POS_GAMMA] = 1'b0;
      high_field[POS_SHUTTER] = 1'b1;
      high_field[POS_GAIN] = 1'b1;
      high_field[POS_IRIS] = 1'b0;
      high_field[POS_FOCUS] = 1'b0;
      high_field[POS_TEMPERATURE] = 1'b0;
      high_field[POS_TRIGGER] = 1'b1;
      high_field[POS_TRIGGER_DELAY] = 1'b0;
      high_field[POS_WHITE_SHADING] = 1'b0;
      high_field[POS_FRAME_RATE_PRIO] = 1'b0;
   end

   always_comb begin
      low_field = '0;
      low_field[POS_ZOOM] = 1'b0;
      low_field[POS_PAN] = 1'b0;
      low_field[POS_TILT] = 1'b0;
      low_field[POS_OPTICAL_FILTER] = 1'b0;
      low_field[POS_CAPTURE_SIZE] = 1'b0;
      low_field[POS_CAPTURE_QUALITY] = 1'b0;
   end

   always_comb begin
      optional_field = '0;
      optional_field[POS_PARALLEL_IO] = 1'b1;
      optional_field[POS_SERIAL_IO] = 1'b0;
      optional_field[POS_STROBE_OUTPUT] = 1'b1;
   end

   // ****************************************************************
   // reserved positions
   // ****************************************************************
   // reserved positions of the high, low and optional maps are masked after they are built, so a later
   // edit of a map cannot leak a stray one onto the bus
   logic [31:0] high_defined;
   logic [31:0] low_defined;
   logic [31:0] optional_defined;
   logic [31:0] high_kept;
   logic [31:0] low_kept;
   logic [31:0] optional_kept;

   always_comb begin
      high_defined = '0;
      low_defined = '0;
      optional_defined = '0;
      for (int i = POS_BRIGHTNESS; i <= POS_FRAME_RATE_PRIO; i++) begin
         high_defined[i] = 1'b1;
      end
      for (int i = POS_ZOOM; i <= POS_OPTICAL_FILTER; i++) begin
         low_defined[i] = 1'b1;
      end
      low_defined[POS_CAPTURE_SIZE] = 1'b1;
      low_defined[POS_CAPTURE_QUALITY] = 1'b1;
      for (int i = POS_PARALLEL_IO; i <= POS_STROBE_OUTPUT; i++) begin
         optional_defined[i] = 1'b1;
      end
   end

   assign high_kept = high_field & high_defined;
   assign low_kept = low_field & low_defined;
   assign optional_kept = optional_field & optional_defined;

   // ****************************************************************
   // field order to bus order
   // ****************************************************************
   logic [31:0] basic_word;
   logic [31:0] high_word;
   logic [31:0] low_word;
   logic [31:0] optional_word;

   quadlet_bit_swap #(.W(32)) u_swap_basic (
      .field_i(basic_field),
      .word_o(basic_word)
   );

   quadlet_bit_swap #(.W(32)) u_swap_high (
      .field_i(high_kept),
      .word_o(high_word)
   );

   quadlet_bit_swap #(.W(32)) u_swap_low (
      .field_i(low_kept),
      .word_o(low_word)
   );

   quadlet_bit_swap #(.W(32)) u_swap_optional (
      .field_i(optional_kept),
      .word_o(optional_word)
   );

   // ****************************************************************
   // ignored-write flag
   // ****************************************************************
   logic ro_write;
   logic status_write;
   logic write_ignored;

   // any write that is not to the selection or status word is dropped
   assign ro_write = write && (word_addr != OFS_VIDEO_SELECT)
      && (word_addr != OFS_INQUIRY_STATUS);
   assign status_write = write && (word_addr == OFS_INQUIRY_STATUS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         write_ignored <= 1'b0;
      end else if (ce_i) begin
         if (ro_write) begin
            write_ignored <= 1'b1;
         end else if (status_write && sel_i[0] && dat_i[STAT_IGNORED_BIT]) begin
            write_ignored <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   logic [DATA_W-1:0] next_dat;

   always_comb begin
      next_dat = '0;
      case (word_addr)
         OFS_BASIC_FUNCTION: begin
            next_dat = basic_word;
         end
         OFS_FEATURE_HIGH: begin
            next_dat = high_word;
         end
         OFS_FEATURE_LOW: begin
            next_dat = low_word;
         end
         OFS_OPTIONAL_FUNCTION: begin
            next_dat = optional_word;
         end
         OFS_VENDOR_POINTER: begin
            next_dat = VENDOR_BLOCK_QUADLETS;
         end
         OFS_PARALLEL_IO_POINTER: begin
            next_dat = PARALLEL_IO_BLOCK_QUADLETS;
         end
         OFS_STROBE_POINTER: begin
            next_dat = STROBE_BLOCK_QUADLETS;
         end
         OFS_VIDEO_SELECT: begin
            next_dat[SEL_FORMAT_LSB +: 3] = video_format;
            next_dat[SEL_MODE_LSB +: 3] = video_mode;
            next_dat[SEL_MONO_BIT] = video_mono;
         end
         OFS_INQUIRY_STATUS: begin
            next_dat[STAT_COLOUR_BIT] = colour_variant;
            next_dat[STAT_IGNORED_BIT] = write_ignored;
         end
         default: begin
            // unmapped words still answer, with zero
            next_dat = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (load && !we_i) begin
         dat_o <= next_dat;
      end
   end

endmodule : camera_feature_inquiry_regs

`default_nettype wire

// ---- hw/feature_inquiry_pkg.sv ----
// constants for the camera feature inquiry register bank
package feature_inquiry_pkg;

   // ****************************************************************
   // bus geometry
   // ****************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [11:0] OFS_BASIC_FUNCTION = 12'h400;
   localparam logic [11:0] OFS_FEATURE_HIGH = 12'h404;
   localparam logic [11:0] OFS_FEATURE_LOW = 12'h408;
   localparam logic [11:0] OFS_OPTIONAL_FUNCTION = 12'h40c;
   localparam logic [11:0] OFS_VENDOR_POINTER = 12'h480;
   localparam logic [11:0] OFS_PARALLEL_IO_POINTER = 12'h484;
   localparam logic [11:0] OFS_STROBE_POINTER = 12'h48c;
   localparam logic [11:0] OFS_VIDEO_SELECT = 12'h7f0;
   localparam logic [11:0] OFS_INQUIRY_STATUS = 12'h7f4;

   // ****************************************************************
   // field positions, numbered with bit 0 as the most significant bit
   // ****************************************************************
   localparam int POS_BRIGHTNESS = 0;
   localparam int POS_AUTO_EXPOSURE = 1;
   localparam int POS_SHARPNESS = 2;
   localparam int POS_WHITE_BALANCE = 3;
   localparam int POS_HUE = 4;
   localparam int POS_SATURATION = 5;
   localparam int POS_GAMMA = 6;
   localparam int POS_SHUTTER = 7;
   localparam int POS_GAIN = 8;
   localparam int POS_IRIS = 9;
   localparam int POS_FOCUS = 10;
   localparam int POS_TEMPERATURE = 11;
   localparam int POS_TRIGGER = 12;
   localparam int POS_TRIGGER_DELAY = 13;
   localparam int POS_WHITE_SHADING = 14;
   localparam int POS_FRAME_RATE_PRIO = 15;

   localparam int POS_ZOOM = 0;
   localparam int POS_PAN = 1;
   localparam int POS_TILT = 2;
   localparam int POS_OPTICAL_FILTER = 3;
   localparam int POS_CAPTURE_SIZE = 16;
   localparam int POS_CAPTURE_QUALITY = 17;

   localparam int POS_PARALLEL_IO = 1;
   localparam int POS_SERIAL_IO = 2;
   localparam int POS_STROBE_OUTPUT = 3;

   localparam int POS_VENDOR_FEATURE = 0;
   localparam int POS_VMODE_ERROR = 1;
   localparam int POS_FEATURE_ERROR = 2;
   localparam int POS_OPTIONAL_CSR = 3;
   localparam int POS_MODE_1394B = 8;
   localparam int POS_POWER_CTRL = 16;
   localparam int POS_ONE_SHOT = 19;
   localparam int POS_MULTI_SHOT = 20;
   localparam int POS_MEM_CHANNEL_MSB = 28;
   localparam int MEM_CHANNEL_W = 4;
   localparam logic [3:0] MEM_CHANNEL_COUNT = 4'h3;

   // ****************************************************************
   // pointer contents, in quadlets from the initial register space
   // ****************************************************************
   localparam logic [31:0] VENDOR_BLOCK_QUADLETS = 32'h0000_0100;
   localparam logic [31:0] PARALLEL_IO_BLOCK_QUADLETS = 32'h0000_0200;
   localparam logic [31:0] STROBE_BLOCK_QUADLETS = 32'h0000_0300;

   // ****************************************************************
   // video select and status fields, ordinary lsb numbering
   // ****************************************************************
   localparam int SEL_FORMAT_LSB = 0;
   localparam int SEL_MODE_LSB = 4;
   localparam int SEL_MONO_BIT = 8;
   localparam logic [2:0] VIDEO_FORMAT_RESET = 3'h0;
   localparam logic [2:0] VIDEO_MODE_RESET = 3'h0;
   localparam logic VIDEO_MONO_RESET = 1'b0;
   localparam int STAT_COLOUR_BIT = 0;
   localparam int STAT_IGNORED_BIT = 1;

endpackage : feature_inquiry_pkg

// ---- hw/quadlet_bit_swap.sv ----
// reverses bit order between msb-first field numbering and the bus word
`timescale 1ns/1ps
`default_nettype none

module quadlet_bit_swap #(
   parameter int W = 32
) (
   input wire logic [W-1:0] field_i,
   output logic [W-1:0] word_o
);

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_swap
         assign word_o[W-1-g] = field_i[g];
      end
   endgenerate

endmodule : quadlet_bit_swap

`default_nettype wire

// ---- hw/wb_word_slave.sv ----
// classic wishbone single-word handshake: one wait state, then ack
`timescale 1ns/1ps
`default_nettype none

module wb_word_slave (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   output logic ack_o,
   output logic load_o,
   output logic write_o
);

   typedef enum logic [0:0] {IDLE, ANSWER} slave_state_t;

   slave_state_t state;
   slave_state_t next_state;

   // ****************************************************************
   // handshake state
   // ****************************************************************
   always_comb begin
      next_state = state;
      case (state)
         IDLE: begin
            if (cyc_i && stb_i) begin
               next_state = ANSWER;
            end
         end
         ANSWER: begin
            // back to idle for a cycle so ack always drops after one cycle
            next_state = IDLE;
         end
         default: begin
            next_state = IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= IDLE;
      end else if (ce_i) begin
         state <= next_state;
      end
   end

   // ack is hidden while frozen: a write cannot land then, so the master must keep waiting
   assign ack_o = ce_i && (state == ANSWER);
   // read data is captured on the edge that raises ack
   assign load_o = ce_i && (state == IDLE) && cyc_i && stb_i;
   // writes land on the edge at which the master samples ack
   assign write_o = ce_i && (state == ANSWER) && cyc_i && stb_i && we_i;

endmodule : wb_word_slave

`default_nettype wire

// ---- verif/camera_feature_inquiry_regs_assertions.sv ----
// concurrent checks on the feature inquiry bank, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module camera_feature_inquiry_regs_assertions
   import feature_inquiry_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [DATA_W-1:0] dat_o,
   input wire logic ack_o
);
   // ****************************************************************
   // request shapes
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence take_s;
      cyc_i && stb_i && !ack_o && ce_i;
   endsequence

   sequence read_s(logic [11:0] a);
      take_s ##0 (!we_i && adr_i[11:2] == a[11:2]);
   endsequence

   // the mask lets the variant-dependent bit through unchecked
   property word_p(logic [11:0] a, logic [31:0] m, logic [31:0] v);
      read_s(a) |=> ack_o && ((dat_o & m) == v);
   endproperty

   // ****************************************************************
   // checks
   // ****************************************************************
   a_ack_latency: assert property (take_s |=> ack_o)
      else $error("no ack in the cycle after a request");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack stood longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without a request");
   a_frozen_quiet: assert property (!ce_i |-> !ack_o)
      else $error("ack shown while the clock enable is low");
   a_write_keeps_data: assert property (take_s ##0 we_i |=> $stable(dat_o))
      else $error("write disturbed read data");
   a_basic_word: assert property (word_p(OFS_BASIC_FUNCTION, 32'hffff_ffff, 32'hf000_1003))
      else $error("basic function word wrong");
   a_high_word: assert property (word_p(OFS_FEATURE_HIGH, 32'hefff_ffff, 32'h8188_0000))
      else $error("high presence word wrong");
   a_low_word: assert property (word_p(OFS_FEATURE_LOW, 32'hffff_ffff, 32'h0000_0000))
      else $error("low presence word not zero");
   a_optional_word: assert property (word_p(OFS_OPTIONAL_FUNCTION, 32'hffff_ffff, 32'h5000_0000))
      else $error("optional function word wrong");
   a_vendor_ptr: assert property (word_p(OFS_VENDOR_POINTER, 32'hffff_ffff, VENDOR_BLOCK_QUADLETS))
      else $error("vendor block pointer wrong");
   a_pio_ptr: assert property (word_p(OFS_PARALLEL_IO_POINTER, 32'hffff_ffff, PARALLEL_IO_BLOCK_QUADLETS))
      else $error("parallel io pointer wrong");
   a_strobe_ptr: assert property (word_p(OFS_STROBE_POINTER, 32'hffff_ffff, STROBE_BLOCK_QUADLETS))
      else $error("strobe pointer wrong");
endmodule : camera_feature_inquiry_regs_assertions

bind camera_feature_inquiry_regs camera_feature_inquiry_regs_assertions chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o)
);

`default_nettype wire

// ---- verif/camera_feature_inquiry_regs_tb.sv ----
// self-checking bench for the feature inquiry register bank
`timescale 1ns/1ps
`default_nettype none

module camera_feature_inquiry_regs_tb
   import feature_inquiry_pkg::*;
;
   // ****************************************************************
   // stimulus and expectations
   // ****************************************************************
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic colour_variant_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [11:0] adr_i = 12'h000;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic [2:0] video_format_o;
   logic [2:0] video_mode_o;
   logic [31:0] q;
   int n_fail = 0;
   int n_tests = 0;

   // field numbering puts bit 0 at the word's msb
   function automatic logic [31:0] fb(input int p);
      return 32'h8000_0000 >> p;
   endfunction : fb

   localparam logic [31:0] HIGH_MONO = fb(POS_BRIGHTNESS) | fb(POS_SHUTTER) | fb(POS_GAIN)
                                      | fb(POS_TRIGGER);
   localparam logic [31:0] HIGH_COL = HIGH_MONO | fb(POS_WHITE_BALANCE);
   localparam logic [31:0] OPT_WORD = fb(POS_PARALLEL_IO) | fb(POS_STROBE_OUTPUT);

   camera_feature_inquiry_regs dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .colour_variant_i(colour_variant_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .video_format_o(video_format_o),
      .video_mode_o(video_mode_o)
   );

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one classic cycle; entered just after a rising edge, leaves one idle cycle behind
   task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
      int k;
      k = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      if (ack_o !== 1'b1) begin
         n_fail++;
         $display("FAIL ack at %h expected 1 seen %b", a, ack_o);
         print_verdict();
      end
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      wb(a, 1'b0, 32'h0, 4'h0, r);
      chk($sformatf("word %h", a), exp, r);
   endtask : rd

   task automatic do_reset(input logic colour);
      rst_i <= 1'b1;
      colour_variant_i <= colour;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("dat_o in reset", 32'h0, dat_o);
      chk("format in reset", 32'h0, {29'h0, video_format_o});
   endtask : do_reset

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_mono_map();
      rd(OFS_BASIC_FUNCTION, 32'hf000_1003);
      rd(OFS_FEATURE_HIGH, HIGH_MONO);
      rd(OFS_FEATURE_LOW, 32'h0);
      rd(OFS_OPTIONAL_FUNCTION, OPT_WORD);
      rd(OFS_VENDOR_POINTER, VENDOR_BLOCK_QUADLETS);
      rd(OFS_PARALLEL_IO_POINTER, PARALLEL_IO_BLOCK_QUADLETS);
      rd(OFS_STROBE_POINTER, STROBE_BLOCK_QUADLETS);
      rd(12'h600, 32'h0);
      rd(OFS_INQUIRY_STATUS, 32'h0);
   endtask : t_mono_map

   // writes to inquiry words are acked, dropped and flagged
   task automatic t_read_only();
      wb(OFS_FEATURE_HIGH, 1'b1, 32'hffff_ffff, 4'hf, q);
      rd(OFS_FEATURE_HIGH, HIGH_MONO);
      wb(OFS_STROBE_POINTER, 1'b1, 32'h0, 4'hf, q);
      rd(OFS_STROBE_POINTER, STROBE_BLOCK_QUADLETS);
      rd(OFS_INQUIRY_STATUS, 32'h2);
      wb(OFS_INQUIRY_STATUS, 1'b1, 32'h2, 4'h1, q);
      rd(OFS_INQUIRY_STATUS, 32'h0);
      wb(12'h600, 1'b1, 32'h1234_5678, 4'hf, q);
      rd(OFS_INQUIRY_STATUS, 32'h2);
      wb(OFS_INQUIRY_STATUS, 1'b1, 32'h2, 4'h1, q);
   endtask : t_read_only

   // colour strap, then the mono selection hides white balance and gives it back
   task automatic t_colour();
      do_reset(1'b1);
      rd(OFS_INQUIRY_STATUS, 32'h1);
      rd(OFS_FEATURE_HIGH, HIGH_COL);
      wb(OFS_VIDEO_SELECT, 1'b1, 32'h0000_0135, 4'h3, q);
      chk("format", 32'h5, {29'h0, video_format_o});
      chk("mode", 32'h3, {29'h0, video_mode_o});
      rd(OFS_FEATURE_HIGH, HIGH_MONO);
      rd(OFS_OPTIONAL_FUNCTION, OPT_WORD);
      wb(OFS_VIDEO_SELECT, 1'b1, 32'h0000_0000, 4'h2, q);
      rd(OFS_FEATURE_HIGH, HIGH_COL);
      chk("format kept", 32'h5, {29'h0, video_format_o});
   endtask : t_colour

   // a request raised while the enable is low waits, then completes once it returns
   task automatic t_freeze();
      ce_i <= 1'b0;
      fork
         wb(OFS_VIDEO_SELECT, 1'b1, 32'h0000_0012, 4'h1, q);
         begin
            repeat (3) @(posedge clk_i);
            chk("ack while frozen", 32'h0, {31'h0, ack_o});
            chk("format while frozen", 32'h5, {29'h0, video_format_o});
            ce_i <= 1'b1;
         end
      join
      chk("format after freeze", 32'h2, {29'h0, video_format_o});
      chk("mode after freeze", 32'h1, {29'h0, video_mode_o});
      rd(OFS_VIDEO_SELECT, 32'h0000_0012);
      rd(OFS_FEATURE_HIGH, HIGH_COL);
   endtask : t_freeze

   initial begin
      do_reset(1'b0);
      t_mono_map();
      t_read_only();
      t_colour();
      t_freeze();
      print_verdict();
   end
endmodule : camera_feature_inquiry_regs_tb

`default_nettype wire
